/* hw/asd_pkg.sv */
/*
  Constants for the angle sensor diagnostic and status register bank:
  register indexes, field positions, reset values and limits.
  Assumes a 100 MHz ref_clk and APB with 32-bit data; the byte address
  of a register is four times its index.
*/
package asd_pkg;
  // timing
  localparam int unsigned CLK_FREQ_MHZ   = 100;
  localparam int unsigned ZC_TIMEOUT_US  = 100;
  localparam int unsigned ZC_TIMEOUT_CYC = ZC_TIMEOUT_US * CLK_FREQ_MHZ;

  // register indexes
  localparam logic [7:0] IDX_CTRL  = 8'h1E;
  localparam logic [7:0] IDX_FAULT = 8'h24;
  localparam logic [7:0] IDX_ALERT = 8'h26;
  localparam logic [7:0] IDX_TEMP  = 8'h28;
  localparam logic [7:0] IDX_FIELD = 8'h2A;
  localparam logic [7:0] IDX_TURN  = 8'h2C;
  localparam logic [7:0] IDX_OFS   = 8'h2E;
  localparam logic [7:0] IDX_FILT  = 8'h30;
  localparam logic [7:0] IDX_FINE  = 8'h32;
  localparam logic [7:0] IDX_ZCA   = 8'h34;
  localparam logic [7:0] IDX_MASK  = 8'h40;
  localparam logic [7:0] IDX_CFG   = 8'h42;

  // fault_flags bits
  localparam int unsigned FB_UVA = 2;
  localparam int unsigned FB_UVD = 3;
  localparam int unsigned FB_OFE = 4;
  localparam int unsigned FB_EUE = 5;
  localparam int unsigned FB_ZIE = 6;
  localparam int unsigned FB_PLK = 7;
  localparam int unsigned FB_ABI = 8;
  localparam int unsigned FB_AVG = 9;
  localparam int unsigned FB_STF = 10;
  localparam int unsigned FB_WAR = 11;

  // alert_flags bits
  localparam int unsigned AB_TOV = 0;
  localparam int unsigned AB_MSH = 1;
  localparam int unsigned AB_BSY = 2;
  localparam int unsigned AB_TCW = 3;
  localparam int unsigned AB_SAT = 4;
  localparam int unsigned AB_ESE = 5;
  localparam int unsigned AB_TMP = 6;
  localparam int unsigned AB_XEE = 7;
  localparam int unsigned AB_SRW = 8;
  localparam int unsigned AB_CRC = 10;
  localparam int unsigned AB_IER = 11;

  // word fields
  localparam int unsigned WORD_PAR = 12;
  localparam int unsigned WORD_SUP = 13;
  localparam int unsigned WORD_SUM = 14;
  localparam int unsigned TURN_SRC = 13;
  localparam int unsigned OFS_LAT  = 14;
  localparam int unsigned CTRL_CLR_FAULT = 8;
  localparam int unsigned CTRL_CLR_ALERT = 9;
  localparam int unsigned MASK_ALERT_LSB = 16;
  localparam int unsigned CFG_RES180     = 12;
  localparam int unsigned CFG_LOWPWR     = 13;
  localparam int unsigned CFG_SLEW       = 14;
  localparam int unsigned CFG_RATE_LSB   = 16;

  // reset values
  localparam logic        TSRC_RST     = 1'b1;
  localparam logic        RES180_RST   = 1'b1;
  localparam logic [11:0] FIELD_HI_RST = 12'hFFF;

  // limits
  localparam logic signed [15:0] TEMP_MIN = -16'sd680;
  localparam logic signed [15:0] TEMP_MAX = 16'sd1240;
  localparam logic signed [11:0] ANG_135  = 12'sd1536;
  localparam logic signed [21:0] TURN_LIM = 22'sh100000;
  localparam logic [3:0]  SHIFT_45      = 4'h9;
  localparam logic [3:0]  SHIFT_180     = 4'hB;
  localparam logic [11:0] AVG_VEL_LIMIT = 12'h800;
  localparam logic [5:0]  SPI_FRAME_BITS = 6'h20;
endpackage

/* hw/asd_diag_regs.sv */
/*
  Diagnostic and status register bank of a magnetic angle sensor:
  latched fault and alert flags, temperature and field readouts, turn
  counter with latched offset, parity-protected angle words, APB slave.
  Assumes every condition input comes from logic on ref_clk and that
  the APB master follows the usual setup/access sequence.
*/
// The APB register port was chosen for this implementation.
// What this block does
// - undervoltage faults at bits 2 and 3, set again while it persists
// - uncorrectable memory read sets fault 5, corrected one alert 5
// - missing zero crossing within the timeout sets fault 6
// - quadrature fault 8, oscillator 4, lock loss 7, self-test 10
// - output rate too high for the velocity sets fault 9
// - fault 11 shows any unmasked alert, forced low by its mask
// - turn counter beyond 256 rotations sets alert 0
// - field above the upper threshold alert 1, saturation alert 4
// - extended access started while one is busy sets alert 2
// - angle step beyond 135 degrees sets alert 3
// - temperature outside -60..180 C sets alert 6 and is clamped
// - failed extended write command sets alert 7
// - slew limiting enabled and applied sets alert 8
// - frame with bad CRC is discarded and sets alert 10
// - bad bit count, data bit 15 or line code error set alert 11
// - temperature is signed 12 bits, eighths of a degree from 25 C
// - turn count is signed 12 bits in 45 or 180 degree steps
// - source bit 1 takes tracking angle, 0 the zero-cross angle
// - turn offset is low 11 or 9 delta bits for 180 or 45 degrees
// - turn count read latches offset and its flag, offset read clears
// - parity bit 12 makes each protected word hold odd ones
// - angles are unsigned 12 bits, plus a 15-bit fine angle
// - low power mode always counts turns from the zero-cross angle
// - bit 13 of both angle words is live masked OR of both undervoltage conditions
// - bit 14 of the turn and both angle words shows any unmasked fault or alert
// - fault bits other than bit 11 stay set until software clears them
// - a clear only removes fault bits already read
`timescale 1ns/1ps
module asd_diag_regs
  import asd_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT = ZC_TIMEOUT_CYC
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // fault conditions
  input  wire logic        uva_cond,
  input  wire logic        uvd_cond,
  input  wire logic        osc_wdog_trip,
  input  wire logic        nvm_rd_done,
  input  wire logic        nvm_multi_err,
  input  wire logic        nvm_single_err,
  input  wire logic        zero_cross_seen,
  input  wire logic        pll_unlock,
  input  wire logic        abi_quad_fail,
  input  wire logic        self_test_fail,
  input  wire logic [11:0] ang_velocity,
  // alert conditions
  input  wire logic        sat_event,
  input  wire logic        ext_access_start,
  input  wire logic        ext_busy,
  input  wire logic        ext_write_fail,
  input  wire logic        slew_limit_hit,
  // measurements
  input  wire logic [15:0] temp_raw,
  input  wire logic [11:0] field_gauss,
  input  wire logic        angle_update,
  input  wire logic [11:0] pll_angle,
  input  wire logic [11:0] zcd_angle,
  input  wire logic [14:0] fine_angle,
  // serial frame check
  input  wire logic        frame_done,
  input  wire logic        frame_crc_ok,
  input  wire logic [5:0]  frame_bit_cnt,
  input  wire logic        frame_data_b15,
  input  wire logic        manchester_err,
  output logic             frame_accept,
  output logic             frame_reject,
  // summary
  output logic             fault_summary_flag
);

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [11:0] fault;
    logic [11:0] alert;
    logic [11:0] fault_rd;
    logic [11:0] alert_rd;
    logic [11:0] fmask;
    logic [11:0] amask;
    logic        res180;
    logic        lowpwr;
    logic        slew_en;
    logic [1:0]  rate;
    logic [11:0] field_hi;
    logic        tsrc;
    logic [21:0] turn_delta;
    logic [11:0] prev_ang;
    logic        prev_valid;
    logic [23:0] zc_cnt;
    logic        lat;
    logic [10:0] ofs_hold;
    logic [11:0] temp;
    logic        frame_accept;
    logic        frame_reject;
    logic        fsum;
  } asd_state_type;

  localparam logic [23:0] ZC_LAST = 24'(ZC_TIMEOUT - 1);

  asd_state_type     s_reg;
  asd_state_type     s_next;
  logic [11:0]       f_set;
  logic [11:0]       a_set;
  logic [11:0]       f_view;
  logic [11:0]       fclr;
  logic [11:0]       aclr;
  logic [7:0]        idx;
  logic              mapped;
  logic              rd_load;
  logic              acc_done;
  logic              war_live;
  logic              supply_low_realtime;
  logic              fsum_live;
  logic [11:0]       src_ang;
  logic signed [11:0] d_ang;
  logic signed [21:0] td_new;
  logic [3:0]        shamt;
  logic [11:0]       turn_cnt;
  logic [10:0]       off_now;
  logic [31:0]       rdata;
  logic [31:0]       wm;
  logic              good_frame;

  // odd parity over the 16-bit word, bit 12 taken as zero on entry
  function automatic logic [15:0] odd_par(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[WORD_PAR] = ~(^w);
    return r;
  endfunction

  // byte-lane merge of write data over the old register value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    s_next = s_reg;
    f_set  = '0;
    a_set  = '0;
    fclr   = '0;
    aclr   = '0;
    wm     = '0;
    idx    = paddr[9:2];
    rd_load  = psel & penable & ~s_reg.pready;
    acc_done = psel & penable & s_reg.pready;

    // live summaries
    war_live = (|(s_reg.alert & ~s_reg.amask)) & ~s_reg.fmask[FB_WAR];
    f_view = {war_live, s_reg.fault[10:0]};
    fsum_live = (|(f_view & ~s_reg.fmask)) |
                (|(s_reg.alert & ~s_reg.amask));
    supply_low_realtime = (uva_cond & ~s_reg.fmask[FB_UVA]) |
                          (uvd_cond & ~s_reg.fmask[FB_UVD]);

    // turn counter view
    shamt = s_reg.res180 ? SHIFT_180 : SHIFT_45;
    turn_cnt = 12'($signed(s_reg.turn_delta) >>> shamt);
    off_now = s_reg.res180 ? s_reg.turn_delta[10:0]
                           : {2'b00, s_reg.turn_delta[8:0]};

    // read mux, undefined bits zero
    mapped = (paddr[11:10] == 2'b00);
    case (idx)
      IDX_CTRL:  rdata = '0;
      IDX_FAULT: rdata = {20'h0, f_view};
      IDX_ALERT: rdata = {20'h0, s_reg.alert};
      IDX_TEMP:  rdata = {20'h0, s_reg.temp};
      IDX_FIELD: rdata = {20'h0, field_gauss};
      IDX_TURN:  rdata = {16'h0, odd_par({1'b0, fsum_live, s_reg.tsrc,
                                          1'b0, turn_cnt})};
      IDX_OFS:   rdata = {16'h0, odd_par({1'b0, s_reg.lat, 3'b000,
                          s_reg.lat ? s_reg.ofs_hold : off_now})};
      IDX_FILT:  rdata = {16'h0, odd_par({1'b0, fsum_live,
                                          supply_low_realtime,
                                          1'b0, pll_angle})};
      IDX_FINE:  rdata = {17'h0, fine_angle};
      IDX_ZCA:   rdata = {16'h0, odd_par({1'b0, fsum_live,
                                          supply_low_realtime,
                                          1'b0, zcd_angle})};
      IDX_MASK:  rdata = {4'h0, s_reg.amask, 4'h0, s_reg.fmask};
      IDX_CFG:   rdata = {14'h0, s_reg.rate, 1'b0, s_reg.slew_en,
                          s_reg.lowpwr, s_reg.res180, s_reg.field_hi};
      default: begin
        rdata  = '0;
        mapped = 1'b0;
      end
    endcase

    // apb answer one cycle into the access phase
    s_next.pready  = rd_load;
    s_next.pslverr = rd_load & ~mapped;
    s_next.prdata  = '0;
    if (rd_load) begin
      s_next.prdata  = (pwrite || !mapped) ? 32'h0 : rdata;
      if (!pwrite && mapped) begin
        if (idx == IDX_FAULT) begin
          s_next.fault_rd = s_reg.fault_rd | f_view;
        end
        if (idx == IDX_ALERT) begin
          s_next.alert_rd = s_reg.alert_rd | s_reg.alert;
        end
        if (idx == IDX_TURN) begin
          s_next.lat  = 1'b1;
          s_next.ofs_hold = off_now;
        end
        if (idx == IDX_OFS) begin
          s_next.lat = 1'b0;
        end
      end
    end

    // writes take effect at the completing edge
    if (acc_done && pwrite && mapped) begin
      case (idx)
        IDX_CTRL: begin
          wm = wmerge(32'h0, pwdata, pstrb);
          if (wm[CTRL_CLR_FAULT]) begin
            fclr = s_reg.fault_rd;
          end
          if (wm[CTRL_CLR_ALERT]) begin
            aclr = s_reg.alert_rd;
          end
        end
        IDX_MASK: begin
          wm = wmerge(rdata, pwdata, pstrb);
          s_next.fmask = wm[11:0];
          s_next.amask = wm[MASK_ALERT_LSB +: 12];
        end
        IDX_CFG: begin
          wm = wmerge(rdata, pwdata, pstrb);
          s_next.field_hi = wm[11:0];
          s_next.res180   = wm[CFG_RES180];
          s_next.lowpwr   = wm[CFG_LOWPWR];
          s_next.slew_en  = wm[CFG_SLEW];
          s_next.rate     = wm[CFG_RATE_LSB +: 2];
        end
        IDX_TURN: begin
          wm = wmerge(rdata, pwdata, pstrb);
          s_next.tsrc = wm[TURN_SRC];
        end
        default: begin
          wm = '0;
        end
      endcase
    end

    // fault events
    f_set[FB_UVA] = uva_cond;
    f_set[FB_UVD] = uvd_cond;
    f_set[FB_OFE] = osc_wdog_trip;
    f_set[FB_EUE] = nvm_rd_done & nvm_multi_err;
    f_set[FB_PLK] = pll_unlock;
    f_set[FB_ABI] = abi_quad_fail;
    f_set[FB_AVG] = ang_velocity > (AVG_VEL_LIMIT >> s_reg.rate);
    f_set[FB_STF] = self_test_fail;

    // zero crossing watchdog
    if (zero_cross_seen) begin
      s_next.zc_cnt = '0;
    end else if (s_reg.zc_cnt == ZC_LAST) begin
      s_next.zc_cnt = '0;
      f_set[FB_ZIE] = 1'b1;
    end else begin
      s_next.zc_cnt = 24'(s_reg.zc_cnt + 24'h1);
    end

    // alert events
    a_set[AB_MSH] = field_gauss > s_reg.field_hi;
    a_set[AB_SAT] = sat_event;
    a_set[AB_BSY] = ext_access_start & ext_busy;
    a_set[AB_ESE] = nvm_rd_done & nvm_single_err & ~nvm_multi_err;
    a_set[AB_XEE] = ext_write_fail;
    a_set[AB_SRW] = s_reg.slew_en & slew_limit_hit;

    // serial frame screening
    good_frame = frame_crc_ok & ~frame_data_b15 &
                 (frame_bit_cnt == SPI_FRAME_BITS);
    a_set[AB_CRC] = frame_done & ~frame_crc_ok;
    a_set[AB_IER] = (frame_done & ((frame_bit_cnt != SPI_FRAME_BITS) |
                    frame_data_b15)) | manchester_err;
    s_next.frame_accept = frame_done & good_frame;
    s_next.frame_reject = frame_done & ~good_frame;

    // temperature clamp
    if ($signed(temp_raw) < TEMP_MIN) begin
      s_next.temp = TEMP_MIN[11:0];
      a_set[AB_TMP] = 1'b1;
    end else if ($signed(temp_raw) > TEMP_MAX) begin
      s_next.temp = TEMP_MAX[11:0];
      a_set[AB_TMP] = 1'b1;
    end else begin
      s_next.temp = temp_raw[11:0];
    end

    // turn counter
    src_ang = (s_reg.lowpwr || !s_reg.tsrc) ? zcd_angle
                                            : pll_angle;
    d_ang = $signed(src_ang - s_reg.prev_ang);
    td_new = 22'($signed(s_reg.turn_delta) + d_ang);
    if (angle_update) begin
      s_next.prev_ang   = src_ang;
      s_next.prev_valid = 1'b1;
      if (s_reg.prev_valid) begin
        if (d_ang > ANG_135 || d_ang < -ANG_135) begin
          a_set[AB_TCW] = 1'b1;
        end
        if (td_new > TURN_LIM || td_new < -TURN_LIM) begin
          a_set[AB_TOV] = 1'b1;
        end else begin
          s_next.turn_delta = td_new;
        end
      end
    end

    // sticky flags, set wins over clear
    s_next.fault = ((s_reg.fault & ~fclr) | f_set) &
                   ~(12'h1 << FB_WAR);
    s_next.alert = (s_reg.alert & ~aclr) | a_set;
    if (!(rd_load && !pwrite && mapped && idx == IDX_FAULT)) begin
      s_next.fault_rd = s_reg.fault_rd & ~fclr;
    end
    if (!(rd_load && !pwrite && mapped && idx == IDX_ALERT)) begin
      s_next.alert_rd = s_reg.alert_rd & ~aclr;
    end
    s_next.fsum = fsum_live;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg          <= '0;
      s_reg.tsrc     <= TSRC_RST;
      s_reg.res180   <= RES180_RST;
      s_reg.field_hi <= FIELD_HI_RST;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign pready             = s_reg.pready;
  assign prdata             = s_reg.prdata;
  assign pslverr            = s_reg.pslverr;
  assign frame_accept       = s_reg.frame_accept;
  assign frame_reject       = s_reg.frame_reject;
  assign fault_summary_flag = s_reg.fsum;

endmodule

/* tb/asd_diag_regs_props.sv */
/*
  Checker for the diagnostic register bank: bus answer timing, frame
  verdicts, word parity and unused upper bits.
  Assumes it sees only the top module's ports, bound below.
*/
`timescale 1ns/1ps
module asd_diag_regs_props
  import asd_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // frames
  input wire logic        frame_done,
  input wire logic        frame_crc_ok,
  input wire logic [5:0]  frame_bit_cnt,
  input wire logic        frame_data_b15,
  input wire logic        frame_accept,
  input wire logic        frame_reject
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic       acc;
  logic       good;
  logic       rdok;
  logic [7:0] idx;
  assign acc  = psel && penable && !pready && clk_en;
  assign good = frame_crc_ok && frame_bit_cnt == SPI_FRAME_BITS
                && !frame_data_b15;
  assign rdok = pready && !pwrite && !pslverr;
  assign idx  = paddr[9:2];
  ans_wait_a: assert property (acc |=> pready && psel && penable)
    else $error("no answer one cycle after access");
  ans_pulse_a: assert property (pready |=> !pready [*2])
    else $error("ready longer than one cycle");
  bad_addr_a: assert property (acc && paddr[11:10] != 2'b00
    |=> pslverr && prdata == 32'h0)
    else $error("high address bits not refused");
  err_only_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  odd_word_a: assert property (rdok && (idx == IDX_TURN
    || idx == IDX_OFS || idx == IDX_FILT || idx == IDX_ZCA)
    |-> ^prdata[15:0])
    else $error("word parity even");
  hi_zero_a: assert property (rdok && idx < IDX_MASK
    |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  frm_good_a: assert property (frame_done && clk_en && good
    |=> frame_accept && !frame_reject)
    else $error("good frame not accepted");
  frm_bad_a: assert property (frame_done && clk_en && !good
    |=> frame_reject && !frame_accept)
    else $error("bad frame not rejected");
  frm_idle_a: assert property (!frame_done
    |=> !frame_accept && !frame_reject)
    else $error("frame verdict without frame");
endmodule

bind asd_diag_regs asd_diag_regs_props asd_diag_regs_props_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .frame_done(frame_done),
  .frame_crc_ok(frame_crc_ok), .frame_bit_cnt(frame_bit_cnt),
  .frame_data_b15(frame_data_b15), .frame_accept(frame_accept),
  .frame_reject(frame_reject)
);

/* tb/asd_diag_regs_test.sv */
/*
  Self-checking bench of the diagnostic register bank: flags, clears,
  readouts and the turn offset latch against an integer model.
  Assumes the checker is bound beside the design.
*/
`timescale 1ns/1ps
module asd_diag_regs_test
  import asd_pkg::*;
;
  logic        ref_clk, arst_n, clk_en, psel, penable, pwrite, pready;
  logic        pslverr, se, uva, multi, single, busy, zc, zc_run, upd;
  logic [1:0]  hi;
  logic        fdone, crc_ok, b15, f_acc, f_rej, fsum;
  logic [11:0] paddr, vel, field, pang, za;
  logic [31:0] pwdata, prdata, rd, rs;
  logic [3:0]  pstrb;
  logic [10:0] ev;
  logic [14:0] fine;
  logic [15:0] temp;
  logic [5:0]  bcnt;
  int          error_cnt, comparisons, fexp, aexp, fm11, td;

  asd_diag_regs #(.ZC_TIMEOUT(20)) asd_diag_regs_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .uva_cond(uva), .uvd_cond(ev[5]),
    .osc_wdog_trip(ev[0]), .nvm_rd_done(ev[4]), .nvm_multi_err(multi),
    .nvm_single_err(single), .zero_cross_seen(zc), .pll_unlock(ev[1]),
    .abi_quad_fail(ev[2]), .self_test_fail(ev[3]), .ang_velocity(vel),
    .sat_event(ev[6]), .ext_access_start(ev[7]), .ext_busy(busy),
    .ext_write_fail(ev[8]), .slew_limit_hit(ev[9]), .temp_raw(temp),
    .field_gauss(field), .angle_update(upd), .pll_angle(pang),
    .zcd_angle(za), .fine_angle(fine), .frame_done(fdone),
    .frame_crc_ok(crc_ok), .frame_bit_cnt(bcnt), .frame_data_b15(b15),
    .manchester_err(ev[10]), .frame_accept(f_acc),
    .frame_reject(f_rej), .fault_summary_flag(fsum)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // zero crossings keep the watchdog quiet while zc_run is high
  always @(posedge ref_clk) begin
    zc <= zc_run && !zc;
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [31:0] par(input logic [31:0] v);
    v[12] = ~^v[15:0];
    return v;
  endfunction

  function automatic int fv();
    return fexp | ((aexp != 0 && fm11 == 0) ? 32'h800 : 0);
  endfunction

  function automatic logic [31:0] fsv();
    return (fv() != 0 || aexp != 0) ? 32'h4000 : 32'h0;
  endfunction

  // expected turn word from the integer delta model
  function automatic logic [31:0] tw(input int sh, input logic [31:0] src);
    return par(32'((td >>> sh) & 32'hFFF) | src | fsv());
  endfunction

  // one turn step on the zero-cross angle, tracking angle half a turn off
  task automatic turn(input int d);
    za <= 12'(za + d);
    pang <= 12'(za + d) ^ 12'h800;
    @(posedge ref_clk);
    if (d > ANG_135 || d < -ANG_135) aexp |= 8;
    if (td + d > TURN_LIM || td + d < -TURN_LIM) begin
      aexp |= 1;
    end else begin
      td += d;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {hi, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [10:0] m);
    ev <= m;
    @(posedge ref_clk);
    ev <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rnd();
    pang <= 12'(xs());
    za <= 12'(xs());
    fine <= 15'(xs());
    idle(2);
  endtask

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  initial begin
    {arst_n, psel, penable, pwrite, uva, multi, single, busy, upd} = '0;
    {fdone, crc_ok, b15, zc, se, paddr, pwdata, pang, za, hi, td} = '0;
    {fine, temp, bcnt, ev, field, rd, fexp, aexp, fm11} = '0;
    {error_cnt, comparisons} = '0;
    clk_en = 1'b1;
    zc_run = 1'b1;
    pstrb = 4'hF;
    rs = 32'h628B103C;
    vel = 12'(xs()) & 12'h7FF;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    idle(4);
    rdc(IDX_TURN, par(32'h2000));
    rdc(IDX_CFG, 32'h1FFF);
    rdc(IDX_FAULT, 32'h0);
    hi = 2'b10;
    rdc(IDX_FAULT, 32'h0);
    hi = 2'b00;
    chk({31'h0, se}, 32'h1);
    apb(1'b0, 8'h3F, 32'h0);
    chk({31'h0, se}, 32'h1);
    multi <= 1'b1;
    vel <= 12'hFFF;
    pulse(11'h01F);
    vel <= 12'h100;
    multi <= 1'b0;
    zc_run <= 1'b0;
    idle(30);
    zc_run <= 1'b1;
    fexp = 32'h7F0;
    rdc(IDX_FAULT, fv());
    chk({31'h0, fsum}, 32'h1);
    rnd();
    rdc(IDX_FILT, par(32'(pang) | fsv()));
    pulse(11'h020);
    apb(1'b1, IDX_CTRL, 32'h100);
    fexp = 32'h008;
    rdc(IDX_FAULT, fv());
    apb(1'b1, IDX_CTRL, 32'h100);
    uva <= 1'b1;
    fexp = 32'h004;
    idle(3);
    rdc(IDX_FAULT, fv());
    rnd();
    rdc(IDX_ZCA, par(32'(za) | 32'h2000 | fsv()));
    apb(1'b1, IDX_CTRL, 32'h100);
    rdc(IDX_FAULT, fv());
    uva <= 1'b0;
    apb(1'b1, IDX_CTRL, 32'h100);
    fexp = 0;
    rdc(IDX_FAULT, 32'h0);
    chk({31'h0, fsum}, 32'h0);
    apb(1'b1, IDX_CFG, 32'h5100);
    field <= 12'h200;
    busy <= 1'b1;
    single <= 1'b1;
    temp <= 16'h07D0;
    pulse(11'h7D0);
    for (int i = 0; i < 4; i++) begin
      crc_ok <= (i != 1);
      bcnt <= (i == 2) ? 6'h1F : SPI_FRAME_BITS;
      b15 <= (i == 3);
      fdone <= 1'b1;
      @(posedge ref_clk);
      fdone <= 1'b0;
      @(posedge ref_clk);
    end
    busy <= 1'b0;
    single <= 1'b0;
    field <= 12'h0FF;
    aexp = 32'hDF6;
    rdc(IDX_ALERT, aexp);
    rdc(IDX_TEMP, 32'h04D8);
    temp <= 16'hFC18;
    idle(2);
    rdc(IDX_TEMP, 32'h0D58);
    temp <= 16'h0010;
    idle(2);
    rdc(IDX_TEMP, 32'h0010);
    rdc(IDX_FIELD, 32'h00FF);
    rdc(IDX_FAULT, fv());
    apb(1'b1, IDX_MASK, 32'h800);
    fm11 = 1;
    rdc(IDX_FAULT, fv());
    apb(1'b1, IDX_MASK, 32'h0);
    fm11 = 0;
    apb(1'b1, IDX_CTRL, 32'h200);
    aexp = 0;
    rdc(IDX_ALERT, 32'h0);
    rdc(IDX_TURN, par(32'h2000 | fsv()));
    rdc(IDX_OFS, par(32'h4000));
    rdc(IDX_OFS, par(32'h0));
    apb(1'b1, IDX_TURN, 32'h0);
    rdc(IDX_TURN, par(32'h0));
    apb(1'b1, IDX_FAULT, 32'hFFFF);
    chk({31'h0, se}, 32'h0);
    rdc(IDX_FAULT, 32'h0);
    rnd();
    rdc(IDX_FINE, 32'(fine));
    upd <= 1'b1;
    turn(0);
    repeat (6) turn(int'(xs() & 32'h3FF));
    turn(1792);
    upd <= 1'b0;
    rdc(IDX_TURN, tw(11, 32'h0));
    rdc(IDX_OFS, par(32'h4000 | 32'(td & 'h7FF)));
    apb(1'b1, IDX_TURN, 32'h2000);
    apb(1'b1, IDX_CFG, 32'h2FFF);
    upd <= 1'b1;
    repeat (4) turn(int'(xs() & 32'h3FF) - 512);
    upd <= 1'b0;
    rdc(IDX_TURN, tw(9, 32'h2000));
    rdc(IDX_OFS, par(32'h4000 | 32'(td & 'h1FF)));
    upd <= 1'b1;
    repeat (1100) turn(1024);
    upd <= 1'b0;
    rdc(IDX_ALERT, aexp);
    rdc(IDX_TURN, tw(9, 32'h2000));
    test_done();
  end
endmodule
